// ---- rtl/vcpu_hyp_pkg.sv ----
package vcpu_hyp_pkg;
   localparam int NUM_LR = 16;
   localparam int ID_W   = 32;

   // system register encoding space
   localparam logic [3:0] COPROC_SYS = 4'hF;
   localparam logic [2:0] OPC1_HYP   = 3'h4;
   localparam logic [3:0] CRN_HYP    = 4'hC;
   localparam logic [3:0] CRM_AP1    = 4'h9;
   localparam logic [3:0] CRM_CTL    = 4'hB;
   localparam logic [2:0] OPC2_HCR   = 3'h0;
   localparam logic [2:0] OPC2_VTR   = 3'h1;
   localparam logic [2:0] OPC2_EISR  = 3'h3;
   localparam logic [2:0] OPC2_ELRSR = 3'h5;

   // exception levels and trap syndrome
   localparam logic [1:0] EL0 = 2'h0;
   localparam logic [1:0] EL1 = 2'h1;
   localparam logic [1:0] EL2 = 2'h2;
   localparam logic [1:0] EL3 = 2'h3;
   localparam logic [5:0] TRAP_CODE = 6'h03;

   // list entry states
   localparam logic [1:0] ST_INACTIVE = 2'h0;
   localparam logic [1:0] ST_PENDING  = 2'h1;
   localparam logic [ID_W-1:0] LPI_BASE = 32'h0000_2000;

   // control register fields
   localparam int CNT_LO   = 27;
   localparam int CNT_W    = 5;
   localparam int TRAP_DEACTIVATE_WRITES_BIT = 14;
   localparam int TRAP_LOCAL_SERROR_BIT = 13;
   localparam int TAL1_BIT = 12;
   localparam int TAL0_BIT = 11;
   localparam int TC_BIT   = 10;
   localparam int VSGI_BIT = 8;
   localparam int EN_BIT   = 0;
   localparam int MEN_LO   = 1;
   localparam int MEN_W    = 7;
   localparam logic [31:0] HCR_RESET = 32'h0000_0000;
   localparam logic [31:0] HCR_BASE_MASK = 32'hF800_1CFF;

   // type info field
   localparam int VTR_PRE_LO = 26;
   localparam int VTR_PRE_W  = 3;

   // guest access classes
   localparam logic [2:0] GCLS_G0     = 3'h0;
   localparam logic [2:0] GCLS_G1     = 3'h1;
   localparam logic [2:0] GCLS_COMMON = 3'h2;
   localparam logic [2:0] GCLS_VDIR   = 3'h3;
   localparam logic [2:0] GCLS_PDIR   = 3'h4;

   typedef struct packed {
      logic       write;
      logic [3:0] coproc;
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
      logic [31:0] wdata;
   } sysreg_req_t;

   typedef struct packed {
      logic [1:0] state;
      logic       hardware_backed;
      logic       maint_on_deact;
   } lr_ctl_t;

   typedef struct packed {
      logic            eoi_wr;
      logic            dir_wr;
      logic            eoi_mode;
      logic [ID_W-1:0] intid;
      logic            entry_found;
      logic            is_vsgi;
      logic            ap_cleared;
   } deact_evt_t;
endpackage

// ---- rtl/access_check.sv ----
module access_check (
   // requester state
   input  wire logic [1:0] el,
   input  wire logic       el2_enabled,
   input  wire logic       hyp_trap_group12,
   input  wire logic       el2_sre_en,
   input  wire logic       el3_sre_en,
   // verdict
   output logic            allow,
   output logic            trap,
   output logic            undef
);
   always_comb begin
      allow = 1'b0;
      trap  = 1'b0;
      unique case (el)
         vcpu_hyp_pkg::EL0: allow = 1'b0;
         vcpu_hyp_pkg::EL1: trap = el2_enabled && hyp_trap_group12;
         vcpu_hyp_pkg::EL2: allow = el2_sre_en;
         vcpu_hyp_pkg::EL3: allow = el3_sre_en;
      endcase
      undef = !allow && !trap;
   end
endmodule

// ---- rtl/virtual_cpu_if_hyp_control.sv ----
// Behaviour
// RULE1 - group1_active_prio index 1 needs 6 preemption bits, 2 and 3 need 7.
// RULE2 - type info register reports preempt_bit_count so software finds present indices.
// RULE3 - software restores group 0 active priorities before any group 1 ones.
// RULE4 - group1_active_prio reached at 15/4/12/9 with opc2 = 0 and index.
// RULE5 - lowest level undefined; guest kernel traps code 0x03 if enabled, else undefined.
// RULE6 - hypervisor or monitor access undefined when its register enable is clear.
// RULE7 - deact_maint_status has one bit per list entry; upper half reads zero.
// RULE8 - maint bit set when entry inactive, not hardware backed, maint_on_deact set.
// RULE9 - deact_maint_status read at 15/4/12/11 with opc2 3.
// RULE10 - empty bit set when inactive and hardware backed or no maint_on_deact.
// RULE11 - empty_entry_status read at 15/4/12/11 with opc2 5.
// RULE12 - deact_overflow_counter counts missed deactivations of non-LPI identifiers.
// RULE13 - end-of-interrupt clearing no active priority may or may not count.
// RULE14 - trap_deactivate_writes traps guest deactivate writes to the hypervisor.
// RULE15 - trap_local_serror sends local system errors to the hypervisor.
// RULE16 - trap_group1_all traps all guest group 1 register accesses.
// RULE17 - trap_group0_all traps all guest group 0 register accesses.
// RULE18 - trap_shared_regs traps guest accesses to registers common to both groups.
// RULE19 - vsgi_deact_count_inhibit stops virtual SGI deactivations counting.
// RULE20 - bit 0 enables the virtual interface; clear blocks maintenance and virtual signalling.
// RULE21 - state 0b01 means pending; no-pending holds while no entry is pending.
// RULE22 - status vectors follow the list entry fields combinationally.
module virtual_cpu_if_hyp_control #(
   parameter int PREEMPT_BITS = 7,
   parameter bit TRAP_DEACTIVATE_WRITES_SUP     = 1'b1,
   parameter bit SERROR_SUPPORT_FLAG_SUP     = 1'b1,
   parameter bit V41_SUP      = 1'b1
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     nrst,
   // system register access
   input  wire logic                     req_valid,
   input  wire vcpu_hyp_pkg::sysreg_req_t req,
   input  wire logic [1:0]               req_el,
   input  wire logic                     el2_enabled,
   input  wire logic                     hyp_trap_group12,
   input  wire logic                     el2_sre_en,
   input  wire logic                     el3_sre_en,
   output logic                          resp_valid_ff,
   output logic                          resp_undef_ff,
   output logic                          resp_trap_ff,
   output logic [5:0]                    resp_code_ff,
   output logic [31:0]                   resp_rdata_ff,
   // list entry control fields
   input  wire vcpu_hyp_pkg::lr_ctl_t [vcpu_hyp_pkg::NUM_LR-1:0] lr_ctl,
   // deactivation events
   input  wire vcpu_hyp_pkg::deact_evt_t deact_evt,
   // guest accesses to interrupt registers
   input  wire logic                     guest_valid,
   input  wire logic                     guest_nsel1,
   input  wire logic                     guest_write,
   input  wire logic [2:0]               guest_class,
   output logic                          guest_trap_ff,
   // local system errors
   input  wire logic                     local_serror,
   output logic                          serror_el2_ff,
   output logic                          serror_el1_ff,
   // control state
   output logic                          vif_enable_ff,
   output logic [vcpu_hyp_pkg::MEN_W-1:0] maint_en_ff,
   output logic                          no_pending_ff,
   output logic                          deact_count_nz_ff
);
   localparam int N = vcpu_hyp_pkg::NUM_LR;
   localparam int CHI = vcpu_hyp_pkg::CNT_LO + vcpu_hyp_pkg::CNT_W - 1;
   localparam int MHI = vcpu_hyp_pkg::MEN_LO + vcpu_hyp_pkg::MEN_W - 1;
   // optional trap and inhibit bits become writable only when supported
   localparam logic [31:0] HCR_WMASK = vcpu_hyp_pkg::HCR_BASE_MASK
      | (32'(TRAP_DEACTIVATE_WRITES_SUP) << vcpu_hyp_pkg::TRAP_DEACTIVATE_WRITES_BIT)
      | (32'(SERROR_SUPPORT_FLAG_SUP) << vcpu_hyp_pkg::TRAP_LOCAL_SERROR_BIT)
      | (32'(V41_SUP) << vcpu_hyp_pkg::VSGI_BIT);

   logic [31:0]  hcr_ff;
   logic [31:0]  ap1_ff [4];
   logic [N-1:0] maint_vec;
   logic [N-1:0] empty_vec;
   logic [N-1:0] pend_vec;
   logic         acc_allow;
   logic         acc_trap;
   logic         acc_undef;
   logic         hit_ap1;
   logic         hit_hcr;
   logic         hit_ro;
   logic [31:0]  rd_mux;
   logic         cnt_inc;
   logic         hcr_wr;
   logic         guest_trap;

   // RULE1
   function automatic logic ap_present(input logic [1:0] idx);
      ap_present = (idx == 2'h0) || (idx == 2'h1 && PREEMPT_BITS >= 6) || (PREEMPT_BITS >= 7);
   endfunction

   function automatic logic in_hyp_space(input vcpu_hyp_pkg::sysreg_req_t r);
      in_hyp_space = r.coproc == vcpu_hyp_pkg::COPROC_SYS && r.opc1 == vcpu_hyp_pkg::OPC1_HYP
                     && r.crn == vcpu_hyp_pkg::CRN_HYP;
   endfunction

   access_check u_check (
      .el               (req_el),
      .el2_enabled      (el2_enabled),
      .hyp_trap_group12 (hyp_trap_group12),
      .el2_sre_en       (el2_sre_en),
      .el3_sre_en       (el3_sre_en),
      .allow            (acc_allow),
      .trap             (acc_trap),
      .undef            (acc_undef)
   );

   // RULE22
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_status
         wire idle = lr_ctl[g].state == vcpu_hyp_pkg::ST_INACTIVE;
         assign maint_vec[g] = idle && !lr_ctl[g].hardware_backed
                               && lr_ctl[g].maint_on_deact; // RULE8
         assign empty_vec[g] = idle && (lr_ctl[g].hardware_backed
                               || !lr_ctl[g].maint_on_deact); // RULE10
         assign pend_vec[g]  = lr_ctl[g].state == vcpu_hyp_pkg::ST_PENDING; // RULE21
      end
   endgenerate

   // decode and read mux
   always_comb begin
      hit_ap1 = in_hyp_space(req) && req.crm == vcpu_hyp_pkg::CRM_AP1
                && !req.opc2[2] && ap_present(req.opc2[1:0]); // RULE4 RULE1
      hit_hcr = in_hyp_space(req) && req.crm == vcpu_hyp_pkg::CRM_CTL
                && req.opc2 == vcpu_hyp_pkg::OPC2_HCR;
      hit_ro  = 1'b0;
      rd_mux  = 32'h0000_0000;
      if (hit_ap1) begin
         rd_mux = ap1_ff[req.opc2[1:0]];
      end else if (hit_hcr) begin
         rd_mux = hcr_ff;
      end else if (in_hyp_space(req) && req.crm == vcpu_hyp_pkg::CRM_CTL) begin
         hit_ro = !req.write;
         unique case (req.opc2)
            vcpu_hyp_pkg::OPC2_VTR: begin
               rd_mux[vcpu_hyp_pkg::VTR_PRE_LO +: vcpu_hyp_pkg::VTR_PRE_W] =
                  vcpu_hyp_pkg::VTR_PRE_W'(PREEMPT_BITS - 1); // RULE2
            end
            vcpu_hyp_pkg::OPC2_EISR: rd_mux[N-1:0] = maint_vec; // RULE9 RULE7
            vcpu_hyp_pkg::OPC2_ELRSR: rd_mux[N-1:0] = empty_vec; // RULE11 RULE10
            default: hit_ro = 1'b0;
         endcase
      end
   end

   // unmapped encodings and absent indices answer undefined
   always_ff @(posedge clk) begin
      if (!nrst) begin
         resp_valid_ff <= 1'b0;
         resp_undef_ff <= 1'b0;
         resp_trap_ff  <= 1'b0;
         resp_code_ff  <= 6'h00;
         resp_rdata_ff <= 32'h0000_0000;
      end else begin
         resp_valid_ff <= req_valid;
         if (req_valid) begin
            resp_trap_ff  <= acc_trap; // RULE5
            resp_code_ff  <= acc_trap ? vcpu_hyp_pkg::TRAP_CODE : 6'h00; // RULE5
            resp_undef_ff <= acc_undef || (acc_allow && !(hit_ap1 || hit_hcr || hit_ro)); // RULE6
            resp_rdata_ff <= (acc_allow && !req.write) ? rd_mux : 32'h0000_0000; // RULE6
         end
      end
   end

   // group 1 active priorities; restore ordering against group 0 is software's job
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            ap1_ff[i] <= 32'h0000_0000;
         end
      end else if (req_valid && req.write && acc_allow && hit_ap1) begin
         ap1_ff[req.opc2[1:0]] <= req.wdata; // RULE4
      end
   end

   // missed deactivation; the no-clear case counts too, which keeps the logic simple
   always_comb begin
      cnt_inc = ((deact_evt.eoi_wr && !deact_evt.eoi_mode)
                 || (deact_evt.dir_wr && deact_evt.eoi_mode))
                && deact_evt.intid < vcpu_hyp_pkg::LPI_BASE
                && !deact_evt.entry_found; // RULE12 RULE13
      if (deact_evt.is_vsgi && hcr_ff[vcpu_hyp_pkg::VSGI_BIT]) begin
         cnt_inc = 1'b0; // RULE19
      end
      hcr_wr = req_valid && req.write && acc_allow && hit_hcr;
   end

   // a write and an increment together: the written count plus one
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hcr_ff <= vcpu_hyp_pkg::HCR_RESET; // RULE14 RULE15 RULE16 RULE17 RULE19
      end else begin
         logic [31:0] base;
         base = hcr_wr ? (req.wdata & HCR_WMASK) : hcr_ff;
         if (cnt_inc) begin
            base[CHI:vcpu_hyp_pkg::CNT_LO] = base[CHI:vcpu_hyp_pkg::CNT_LO] + 5'h01; // RULE12
         end
         hcr_ff <= base;
      end
   end

   // guest access traps
   always_comb begin
      guest_trap = 1'b0;
      unique case (guest_class)
         vcpu_hyp_pkg::GCLS_G0: guest_trap = hcr_ff[vcpu_hyp_pkg::TAL0_BIT]; // RULE17
         vcpu_hyp_pkg::GCLS_G1: guest_trap = hcr_ff[vcpu_hyp_pkg::TAL1_BIT]; // RULE16
         vcpu_hyp_pkg::GCLS_COMMON: guest_trap = hcr_ff[vcpu_hyp_pkg::TC_BIT]; // RULE18
         vcpu_hyp_pkg::GCLS_VDIR, vcpu_hyp_pkg::GCLS_PDIR: begin
            guest_trap = hcr_ff[vcpu_hyp_pkg::TC_BIT]
                         || (guest_write && hcr_ff[vcpu_hyp_pkg::TRAP_DEACTIVATE_WRITES_BIT]); // RULE14 RULE18
         end
         default: guest_trap = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         guest_trap_ff <= 1'b0;
      end else begin
         guest_trap_ff <= guest_valid && guest_nsel1 && guest_trap;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         serror_el2_ff <= 1'b0;
         serror_el1_ff <= 1'b0;
      end else begin
         serror_el2_ff <= local_serror && hcr_ff[vcpu_hyp_pkg::TRAP_LOCAL_SERROR_BIT]; // RULE15
         serror_el1_ff <= local_serror && !hcr_ff[vcpu_hyp_pkg::TRAP_LOCAL_SERROR_BIT]; // RULE15
      end
   end

   // maintenance enables are gated by the global enable; the no-pending and count flags are not
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vif_enable_ff     <= 1'b0;
         maint_en_ff       <= '0;
         no_pending_ff     <= 1'b0;
         deact_count_nz_ff <= 1'b0;
      end else begin
         vif_enable_ff     <= hcr_ff[vcpu_hyp_pkg::EN_BIT]; // RULE20
         maint_en_ff       <= hcr_ff[vcpu_hyp_pkg::EN_BIT]
                              ? hcr_ff[MHI:vcpu_hyp_pkg::MEN_LO] : '0; // RULE20
         no_pending_ff     <= ~|pend_vec; // RULE21
         deact_count_nz_ff <= |hcr_ff[CHI:vcpu_hyp_pkg::CNT_LO];
      end
   end

   a_undef_low_el: assert property (@(posedge clk) disable iff (!nrst) // RULE5
      req_valid && req_el == vcpu_hyp_pkg::EL0 |=> resp_valid_ff && resp_undef_ff)
      else $error("lowest level access not undefined");
   a_trap_code_val: assert property (@(posedge clk) disable iff (!nrst) // RULE5
      req_valid && req_el == vcpu_hyp_pkg::EL1 && el2_enabled && hyp_trap_group12
      |=> resp_trap_ff && resp_code_ff == 6'h03 && !resp_undef_ff)
      else $error("guest kernel trap wrong");
   a_sre_undef: assert property (@(posedge clk) disable iff (!nrst) // RULE6
      req_valid && req_el == vcpu_hyp_pkg::EL2 && !el2_sre_en |=> resp_undef_ff)
      else $error("hypervisor access without enable not undefined");
   a_ap_absent: assert property (@(posedge clk) disable iff (!nrst) // RULE1
      req_valid && in_hyp_space(req) && req.crm == vcpu_hyp_pkg::CRM_AP1
      && req.opc2 == 3'h3 && PREEMPT_BITS < 7 |=> resp_undef_ff)
      else $error("absent index accepted");
   a_maint_read: assert property (@(posedge clk) disable iff (!nrst) // RULE9
      req_valid && !req.write && acc_allow && in_hyp_space(req)
      && req.crm == vcpu_hyp_pkg::CRM_CTL && req.opc2 == vcpu_hyp_pkg::OPC2_EISR
      |=> resp_rdata_ff == {16'h0000, $past(maint_vec)} && !resp_undef_ff)
      else $error("maintenance status read wrong");
   a_empty_excl: assert property (@(posedge clk) disable iff (!nrst) // RULE10
      (maint_vec & empty_vec) == '0)
      else $error("entry both empty and awaiting maintenance");
   a_count_inc: assert property (@(posedge clk) disable iff (!nrst) // RULE12
      cnt_inc && !hcr_wr |=> hcr_ff[CHI:vcpu_hyp_pkg::CNT_LO]
      == $past(hcr_ff[CHI:vcpu_hyp_pkg::CNT_LO]) + 5'h01)
      else $error("overflow counter did not step");
   a_count_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE19
      !cnt_inc && !hcr_wr |=> $stable(hcr_ff))
      else $error("control register changed spontaneously");
   a_guest_g1: assert property (@(posedge clk) disable iff (!nrst) // RULE16
      guest_valid && guest_nsel1 && guest_class == vcpu_hyp_pkg::GCLS_G1
      |=> guest_trap_ff == $past(hcr_ff[vcpu_hyp_pkg::TAL1_BIT]))
      else $error("group 1 guest trap wrong");
   a_serror_route: assert property (@(posedge clk) disable iff (!nrst) // RULE15
      local_serror |=> serror_el2_ff != serror_el1_ff)
      else $error("local system error misrouted");
   a_vif_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE20
      !vif_enable_ff |-> maint_en_ff == '0)
      else $error("maintenance enabled while interface off");
   a_guest_g0: assert property (@(posedge clk) disable iff (!nrst) // RULE17
      guest_valid && guest_nsel1 && guest_class == vcpu_hyp_pkg::GCLS_G0
      |=> guest_trap_ff == $past(hcr_ff[vcpu_hyp_pkg::TAL0_BIT]))
      else $error("group 0 guest trap wrong");
   a_guest_common: assert property (@(posedge clk) disable iff (!nrst) // RULE18
      guest_valid && guest_nsel1 && guest_class == vcpu_hyp_pkg::GCLS_COMMON
      |=> guest_trap_ff == $past(hcr_ff[vcpu_hyp_pkg::TC_BIT]))
      else $error("common register guest trap wrong");
   a_dir_trap: assert property (@(posedge clk) disable iff (!nrst) // RULE14
      guest_valid && guest_nsel1 && guest_write && guest_class == vcpu_hyp_pkg::GCLS_VDIR
      && hcr_ff[vcpu_hyp_pkg::TRAP_DEACTIVATE_WRITES_BIT] |=> guest_trap_ff)
      else $error("virtual deactivate write not trapped");
   a_pend_seen: assert property (@(posedge clk) disable iff (!nrst) // RULE21
      |pend_vec |=> !no_pending_ff)
      else $error("no-pending shown while an entry is pending");
endmodule

// ---- bench/core_model.sv ----
module core_model (
   // clock
   input  wire logic                   clk,
   // request
   output logic                        req_valid,
   output vcpu_hyp_pkg::sysreg_req_t   req,
   output logic [1:0]                  req_el,
   output logic                        el2_enabled,
   output logic                        hyp_trap_group12,
   output logic                        el2_sre_en,
   output logic                        el3_sre_en,
   // response
   input  wire logic                   resp_valid_ff,
   input  wire logic                   resp_undef_ff,
   input  wire logic                   resp_trap_ff,
   input  wire logic [5:0]             resp_code_ff,
   input  wire logic [31:0]            resp_rdata_ff
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      req_valid = 1'b0;
      req = '0;
      req_el = vcpu_hyp_pkg::EL2;
      {el2_enabled, hyp_trap_group12, el2_sre_en, el3_sre_en} = 4'h0;
   end

   // one access; answer sampled one cycle after the request edge
   task automatic access(input logic wr, input logic [3:0] crm, input logic [2:0] op2,
                         input logic [31:0] wd, input logic [1:0] el, input logic [3:0] cfg,
                         output logic [31:0] rd, output logic [2:0] st, output logic [5:0] code);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: wr, coproc: vcpu_hyp_pkg::COPROC_SYS, opc1: vcpu_hyp_pkg::OPC1_HYP,
               crn: vcpu_hyp_pkg::CRN_HYP, crm: crm, opc2: op2, wdata: wd};
      req_el <= el;
      {el2_enabled, hyp_trap_group12, el2_sre_en, el3_sre_en} <= cfg;
      @(posedge clk);
      req_valid <= 1'b0;
      // idle bus must not keep showing the last request
      req <= vcpu_hyp_pkg::sysreg_req_t'(~req);
      #1;
      rd = resp_rdata_ff;
      st = {resp_valid_ff, resp_undef_ff, resp_trap_ff};
      code = resp_code_ff;
   endtask
endmodule

// ---- bench/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] OK  = 3'b100;
   localparam logic [2:0] UND = 3'b110;
   localparam logic [2:0] TRP = 3'b101;

   logic                        clk;
   logic                        nrst;
   logic                        req_valid;
   vcpu_hyp_pkg::sysreg_req_t   req;
   logic [1:0]                  req_el;
   logic                        el2_enabled;
   logic                        hyp_trap_group12;
   logic                        el2_sre_en;
   logic                        el3_sre_en;
   logic                        resp_valid_ff;
   logic                        resp_undef_ff;
   logic                        resp_trap_ff;
   logic [5:0]                  resp_code_ff;
   logic [31:0]                 resp_rdata_ff;
   vcpu_hyp_pkg::lr_ctl_t [vcpu_hyp_pkg::NUM_LR-1:0] lr_ctl;
   vcpu_hyp_pkg::deact_evt_t    deact_evt;
   logic                        guest_valid;
   logic                        guest_nsel1;
   logic                        guest_write;
   logic [2:0]                  guest_class;
   logic                        guest_trap_ff;
   logic                        local_serror;
   logic                        serror_el2_ff;
   logic                        serror_el1_ff;
   logic                        vif_enable_ff;
   logic [6:0]                  maint_en_ff;
   logic                        no_pending_ff;
   logic                        deact_count_nz_ff;
   logic [31:0]                 e_maint;
   logic [31:0]                 e_empty;
   int                          n_errors;
   int                          checked;

   core_model u_core_model (.clk(clk), .req_valid(req_valid), .req(req), .req_el(req_el),
      .el2_enabled(el2_enabled), .hyp_trap_group12(hyp_trap_group12), .el2_sre_en(el2_sre_en),
      .el3_sre_en(el3_sre_en), .resp_valid_ff(resp_valid_ff), .resp_undef_ff(resp_undef_ff),
      .resp_trap_ff(resp_trap_ff), .resp_code_ff(resp_code_ff), .resp_rdata_ff(resp_rdata_ff));

   virtual_cpu_if_hyp_control #(.PREEMPT_BITS(7), .TRAP_DEACTIVATE_WRITES_SUP(1'b1), .SERROR_SUPPORT_FLAG_SUP(1'b1),
      .V41_SUP(1'b1)) u_virtual_cpu_if_hyp_control (.clk(clk), .nrst(nrst),
      .req_valid(req_valid), .req(req), .req_el(req_el), .el2_enabled(el2_enabled),
      .hyp_trap_group12(hyp_trap_group12), .el2_sre_en(el2_sre_en), .el3_sre_en(el3_sre_en),
      .resp_valid_ff(resp_valid_ff), .resp_undef_ff(resp_undef_ff),
      .resp_trap_ff(resp_trap_ff), .resp_code_ff(resp_code_ff),
      .resp_rdata_ff(resp_rdata_ff), .lr_ctl(lr_ctl), .deact_evt(deact_evt),
      .guest_valid(guest_valid), .guest_nsel1(guest_nsel1), .guest_write(guest_write),
      .guest_class(guest_class), .guest_trap_ff(guest_trap_ff), .local_serror(local_serror),
      .serror_el2_ff(serror_el2_ff), .serror_el1_ff(serror_el1_ff),
      .vif_enable_ff(vif_enable_ff), .maint_en_ff(maint_en_ff),
      .no_pending_ff(no_pending_ff), .deact_count_nz_ff(deact_count_nz_ff));

   always #25 clk = ~clk;

   task automatic stop_test();
      $display("errors %0d of %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] op2,
                      input logic [31:0] wd, input logic [1:0] el, input logic [3:0] cfg,
                      input logic [31:0] erd, input logic [2:0] est);
      logic [31:0] rd;
      logic [2:0]  st;
      logic [5:0]  code;
      u_core_model.access(wr, crm, op2, wd, el, cfg, rd, st, code);
      chk(rd, erd);
      chk(32'({st, code}), 32'({est, (est == TRP) ? vcpu_hyp_pkg::TRAP_CODE : 6'h00}));
   endtask

   task automatic ctl_wr(input logic [31:0] v);
      acc(1'b1, vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, v, vcpu_hyp_pkg::EL2, 4'hF,
          32'h0, OK);
   endtask

   task automatic ctl_rd(input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] e);
      acc(1'b0, crm, op2, 32'h0, vcpu_hyp_pkg::EL2, 4'hF, e, OK);
   endtask

   // flags: eoi_wr, dir_wr, eoi_mode, entry_found, is_vsgi
   task automatic evt(input logic [4:0] f, input logic [31:0] id);
      @(posedge clk);
      deact_evt <= '{eoi_wr: f[4], dir_wr: f[3], eoi_mode: f[2], intid: id,
                     entry_found: f[1], is_vsgi: f[0], ap_cleared: 1'b0};
      @(posedge clk);
      deact_evt <= '0;
   endtask

   task automatic gst(input logic ns, input logic wr, input logic [2:0] cls, input logic e);
      @(posedge clk);
      guest_valid <= 1'b1;
      guest_nsel1 <= ns;
      guest_write <= wr;
      guest_class <= cls;
      local_serror <= 1'b1;
      @(posedge clk);
      guest_valid <= 1'b0;
      local_serror <= 1'b0;
      #1;
      chk(32'(guest_trap_ff), 32'(e));
   endtask

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      lr_ctl = '0;
      deact_evt = '0;
      {guest_valid, guest_nsel1, guest_write, guest_class, local_serror} = '0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      chk(32'({vif_enable_ff, maint_en_ff, deact_count_nz_ff}), 32'h0);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, 32'h0);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_VTR, 32'h1800_0000);
      // group 0 priorities live elsewhere, so writing group 1 here keeps the order
      for (int i = 0; i < 4; i++) begin
         ctl_wr(32'h0);
         acc(1'b1, vcpu_hyp_pkg::CRM_AP1, i[2:0], {4{8'hA0 + i[7:0]}}, vcpu_hyp_pkg::EL3, 4'h1,
             32'h0, OK);
      end
      for (int i = 0; i < 4; i++) begin
         ctl_rd(vcpu_hyp_pkg::CRM_AP1, i[2:0], {4{8'hA0 + i[7:0]}});
      end
      acc(1'b1, vcpu_hyp_pkg::CRM_AP1, 3'h0, 32'hDEAD_BEEF, vcpu_hyp_pkg::EL1, 4'hF, 0, TRP);
      acc(1'b0, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL0, 4'hF, 0, UND);
      acc(1'b0, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL1, 4'h7, 0, UND);
      acc(1'b0, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL1, 4'hB, 0, UND);
      acc(1'b1, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL2, 4'hD, 0, UND);
      acc(1'b1, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL3, 4'hE, 0, UND);
      acc(1'b0, vcpu_hyp_pkg::CRM_AP1, 3'h0, 0, vcpu_hyp_pkg::EL2, 4'h2, 32'hA0A0_A0A0, OK);
      acc(1'b0, vcpu_hyp_pkg::CRM_AP1, 3'h4, 0, vcpu_hyp_pkg::EL2, 4'hF, 0, UND);
      acc(1'b0, 4'h8, 3'h0, 0, vcpu_hyp_pkg::EL2, 4'hF, 0, UND);
      acc(1'b1, vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_EISR, 0, vcpu_hyp_pkg::EL2, 4'hF,
          0, UND);
      // three list patterns, the last one fully idle
      for (int p = 0; p < 3; p++) begin
         @(posedge clk);
         e_maint = 32'h0;
         e_empty = 32'h0;
         for (int i = 0; i < 16; i++) begin
            lr_ctl[i] <= '{(p == 2) ? 2'h0 : i[1:0] ^ p[1:0], i[2], i[3] ^ p[0]};
            e_maint[i] = (p == 2 || i[1:0] == p[1:0]) && !i[2] && (i[3] ^ p[0]);
            e_empty[i] = (p == 2 || i[1:0] == p[1:0]) && (i[2] || !(i[3] ^ p[0]));
         end
         ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_EISR, e_maint);
         ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_ELRSR, e_empty);
         chk(32'(no_pending_ff), 32'(p == 2));
      end
      ctl_wr(32'hFFFF_FFFF);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, 32'hF800_7DFF);
      chk(32'({vif_enable_ff, maint_en_ff}), 32'hFF);
      ctl_wr(32'h0000_00FE);
      #50;
      chk(32'({vif_enable_ff, maint_en_ff}), 32'h0);
      ctl_wr(32'h0000_0101);
      evt(5'b10001, 32'd3);
      evt(5'b10000, 32'd100);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, 32'h0800_0101);
      ctl_wr(32'h0000_0001);
      evt(5'b10000, 32'd8191);
      evt(5'b10000, 32'd8192);
      evt(5'b10010, 32'd5);
      evt(5'b01100, 32'd7);
      evt(5'b01000, 32'd7);
      evt(5'b10100, 32'd7);
      evt(5'b01101, 32'd3);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, 32'h1800_0001);
      chk(32'(deact_count_nz_ff), 32'h1);
      ctl_wr(32'hF800_0001);
      evt(5'b10000, 32'd9);
      ctl_rd(vcpu_hyp_pkg::CRM_CTL, vcpu_hyp_pkg::OPC2_HCR, 32'h0000_0001);
      chk(32'(deact_count_nz_ff), 32'h0);
      for (int s = 0; s < 5; s++) begin
         ctl_wr((32'h1 << (10 + s)) | 32'h1);
         for (int c = 0; c < 5; c++) begin
            for (int w = 0; w < 2; w++) begin
               gst(1'b1, w[0], c[2:0], (c == 0 && s == 1) || (c == 1 && s == 2) ||
                   (c >= 2 && s == 0) || (c >= 3 && s == 4 && w == 1));
            end
         end
         chk(32'({serror_el2_ff, serror_el1_ff}), (s == 3) ? 32'h2 : 32'h1);
      end
      ctl_wr(32'h0000_7C01);
      gst(1'b0, 1'b1, 3'h3, 1'b0);
      stop_test();
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      stop_test();
   end
endmodule
